// ==== verilog/lindyn_ctrl.sv ====
// LIN slave command handling: dynamic id store, command decode, bus-loss.
// Assumes frames arrive already checked as a one-cycle valid pulse on mclk.
// Operation
// RULE1: Ids 0x3C and 0x3F are command/extended frames, never assignable.
// RULE2: Assignment is 0x3C frame with data1 0x80 and command byte 0x91.
// RULE3: Each assignment frame carries four id/pointer pairs; three frames fill all slots.
// RULE4: Address bit7 zero means broadcast; otherwise physical address must match.
// RULE5: Bytes 4 and 5 unpack id1 and pointer1, id2 low bits, pointer2.
// RULE6: Bytes 6 to 8 unpack pointer3, id2 high, pointer4, id3, id4.
// RULE7: Pointer codes select position, status, move, short moves, general, preparation slots.
// RULE8: Command codes decode into read, write and assignment classes.
// RULE9: Ids with low three bits variable address at most eight nodes.
// RULE10: Bus-lost flag after 25000 frame periods without valid traffic.
// RULE11: Bus lost with safe position not 0x400: move there, then sleep.
// RULE12: Bus lost with safe position 0x400: sleep directly.
// RULE13: Safe move copies 11-bit safe position into target position.
// RULE14: Safe position used is the RAM copy.
// RULE15: Floating address pin two behaves as bus loss.
// RULE16: Without a full-state read since power-up, stay in shutdown, motor unpowered.
// RULE17: Indirect read honoured only directly after a preparing frame for this node.
// RULE18: Pairs with undefined pointer codes are ignored.
`default_nettype none
module lindyn_ctrl #(
   parameter int LOST_FRAMES_P  = lindyn_pkg::LOST_FRAMES,
   parameter int FRAME_CYCLES_P = lindyn_pkg::FRAME_CYCLES
) (
   input  wire logic                      mclk,
   input  wire logic                      arst_n,
   input  wire logic                      frame_valid,
   input  wire lindyn_pkg::lindyn_frame_t frame_in,
   input  wire logic [6:0]                node_addr,
   input  wire logic                      hardwired_addr_pin_two_float,
   input  wire logic [10:0]               safe_target_pos,
   input  wire logic [15:0]               current_pos_reg,
   input  wire logic                      move_done,
   output logic [5:0]                     assigned_frame_ident [lindyn_pkg::SLOT_COUNT],
   output logic [15:0]                    move_target_pos,
   output logic                           safe_move_start,
   output logic                           motor_powered,
   output logic                           sleep_req,
   output logic                           bus_lost,
   output logic                           cmd_strobe,
   output logic [6:0]                     cmd_code,
   output lindyn_pkg::lindyn_cmd_class_t  cmd_class,
   output logic                           indirect_read_ok
);
   import lindyn_pkg::*;

   function automatic lindyn_cmd_class_t classify(input logic [6:0] c);
      lindyn_cmd_class_t r;
      r = '0;
      if (c <= CMD_READ_SHORT)
         r.read_cmd = 1'b1; // RULE8
      else if ((c <= CMD_MOTION_PARAM) || ((c >= CMD_MOVE_TARGET) && (c <= CMD_OTP_PROG)))
         r.write_cmd = 1'b1; // RULE8
      else if (c == CMD_ASSIGN_ID)
         r.assign_cmd = 1'b1; // RULE8
      return r;
   endfunction : classify

   logic        rst_s1;
   logic        rst_n;
   logic        pin2_s1;
   logic        pin2_s2;
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rst_s1 <= 1'b0;
         rst_n  <= 1'b0;
      end
      else
      begin
         rst_s1 <= 1'b1;
         rst_n  <= rst_s1;
      end
   end

   // Address pin is asynchronous to mclk
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin2_s1 <= 1'b0;
         pin2_s2 <= 1'b0;
      end
      else
      begin
         pin2_s1 <= hardwired_addr_pin_two_float;
         pin2_s2 <= pin2_s1;
      end
   end

   logic       is_cmd_frame;
   logic       addr_hit;
   logic       assign_frame;
   logic [5:0] pair_id  [PAIRS_PER_FRAME];
   logic [3:0] pair_ptr [PAIRS_PER_FRAME];
   assign is_cmd_frame = frame_in.ident == ID_CMD_FRAME; // RULE1
   assign addr_hit = !frame_in.d3[7] || (frame_in.d3[6:0] == node_addr); // RULE4
   assign assign_frame = frame_valid && is_cmd_frame && (frame_in.d1 == APP_CMD_MARKER)
                         && frame_in.d2[7] && (frame_in.d2[6:0] == CMD_ASSIGN_ID); // RULE2
   assign pair_id[0]  = {frame_in.d5[1:0], frame_in.d4[7:4]}; // RULE5
   assign pair_ptr[0] = frame_in.d4[3:0]; // RULE5
   assign pair_id[1]  = {frame_in.d6[3:0], frame_in.d5[7:6]}; // RULE5
   assign pair_ptr[1] = frame_in.d5[5:2]; // RULE5
   assign pair_ptr[2] = frame_in.d6[7:4]; // RULE6
   assign pair_id[2]  = frame_in.d7[5:0]; // RULE6
   assign pair_ptr[3] = {frame_in.d8[1:0], frame_in.d7[7:6]}; // RULE6
   assign pair_id[3]  = frame_in.d8[7:2]; // RULE6

   // Later pairs win when a frame names one slot twice
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         for (int s = 0; s < SLOT_COUNT; s++)
            assigned_frame_ident[s] <= ID_RESET_VAL;
      else if (assign_frame && addr_hit) // RULE4
         for (int p = 0; p < PAIRS_PER_FRAME; p++) // RULE3
            if ((pair_ptr[p] <= SLOT_MAX) && (pair_id[p] != ID_CMD_FRAME)
                && (pair_id[p] != ID_EXT_FRAME)) // RULE18 RULE1
               assigned_frame_ident[pair_ptr[p][3:0]] <= pair_id[p]; // RULE7 RULE9
   end

   // Command decode of 0x3c frames with data1 0x80 and bit7 set in data2, address filtered
   logic cmd_frame_ok;
   // Decoded once: a member cannot be selected straight off a call
   lindyn_cmd_class_t frame_class;
   assign frame_class  = classify(frame_in.d2[6:0]); // RULE8
   assign cmd_frame_ok = frame_valid && is_cmd_frame && (frame_in.d1 == APP_CMD_MARKER)
                         && frame_in.d2[7] && addr_hit;
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cmd_strobe <= 1'b0;
         cmd_code   <= 7'h00;
         cmd_class  <= '0;
      end
      else
      begin
         cmd_strobe <= cmd_frame_ok;
         if (cmd_frame_ok)
         begin
            cmd_code  <= frame_in.d2[6:0];
            cmd_class <= frame_class; // RULE8
         end
      end
   end

   // Preparing frame arms exactly the next frame
   logic prep_armed_reg;
   logic prep_frame;
   logic prep_dyn;
   assign prep_dyn   = frame_in.ident == assigned_frame_ident[SLOT_MAX] && frame_in.d1[7]
                       && frame_in.d2[7] && (frame_in.d2[6:0] == node_addr);
   assign prep_frame = frame_valid && ((cmd_frame_ok && frame_in.d3[7]
                       && frame_class.read_cmd) || prep_dyn);
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         prep_armed_reg <= 1'b0;
      else if (frame_valid)
         prep_armed_reg <= prep_frame; // RULE17
   end
   assign indirect_read_ok = prep_armed_reg; // RULE17

   // Frame-period divider and silent-frame counter
   logic [$clog2(FRAME_CYCLES_P+1)-1:0] div_reg;
   logic [$clog2(LOST_FRAMES_P+1)-1:0]  lost_cnt_reg;
   logic                                frame_tick;
   assign frame_tick = div_reg == ($bits(div_reg))'(FRAME_CYCLES_P - 1);
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         div_reg <= '0;
      else if (frame_valid || frame_tick)
         div_reg <= '0;
      else
         div_reg <= div_reg + 1'b1;
   end
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lost_cnt_reg <= '0;
         bus_lost     <= 1'b0;
      end
      else if (frame_valid)
      begin
         lost_cnt_reg <= '0;
         bus_lost     <= 1'b0;
      end
      else if (frame_tick && !bus_lost)
      begin
         lost_cnt_reg <= lost_cnt_reg + 1'b1;
         if (lost_cnt_reg == ($bits(lost_cnt_reg))'(LOST_FRAMES_P - 1))
            bus_lost <= 1'b1; // RULE10
      end
   end

   // Main power state
   lindyn_state_t state_reg;
   logic          full_read_seen;
   logic          lost_event;
   assign full_read_seen = cmd_frame_ok && (frame_in.d2[6:0] == CMD_READ_FULL);
   assign lost_event = bus_lost || pin2_s2; // RULE15
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg       <= ST_SHUTDOWN;
         move_target_pos <= 16'h0000;
         safe_move_start <= 1'b0;
      end
      else
      begin
         safe_move_start <= 1'b0;
         case (state_reg)
            ST_SHUTDOWN:
               if (full_read_seen)
                  state_reg <= ST_NORMAL; // RULE16
            ST_NORMAL:
               if (lost_event)
               begin
                  if (safe_target_pos == SAFE_POS_NONE) // RULE14
                     state_reg <= ST_SLEEP; // RULE12
                  else
                  begin
                     move_target_pos <= {{5{safe_target_pos[10]}}, safe_target_pos}; // RULE13
                     safe_move_start <= 1'b1; // RULE11
                     state_reg       <= ST_SAFE_MOVE;
                  end
               end
            ST_SAFE_MOVE:
               if (move_done)
                  state_reg <= ST_SLEEP; // RULE11
            ST_SLEEP:
               state_reg <= ST_SLEEP;
            default:
               state_reg <= ST_SHUTDOWN;
         endcase
      end
   end
   assign motor_powered = (state_reg == ST_NORMAL) || (state_reg == ST_SAFE_MOVE); // RULE16
   assign sleep_req     = state_reg == ST_SLEEP;
endmodule : lindyn_ctrl
`default_nettype wire

// ==== verilog/lindyn_pkg.sv ====
// Package for the LIN dynamic identifier and bus-loss controller.
// Assumes a single 100 MHz clock domain.
`default_nettype none
package lindyn_pkg;
   localparam logic [5:0]  ID_CMD_FRAME     = 6'h3c;
   localparam logic [5:0]  ID_EXT_FRAME     = 6'h3f;
   localparam logic [7:0]  APP_CMD_MARKER   = 8'h80;
   localparam logic [6:0]  CMD_READ_POS     = 7'h00;
   localparam logic [6:0]  CMD_READ_FULL    = 7'h01;
   localparam logic [6:0]  CMD_READ_OTP     = 7'h02;
   localparam logic [6:0]  CMD_READ_SHORT   = 7'h03;
   localparam logic [6:0]  CMD_GO_SAFE      = 7'h04;
   localparam logic [6:0]  CMD_HALT         = 7'h05;
   localparam logic [6:0]  CMD_ZERO_POS     = 7'h06;
   localparam logic [6:0]  CMD_RELOAD       = 7'h07;
   localparam logic [6:0]  CMD_TWO_TARGET   = 7'h08;
   localparam logic [6:0]  CMD_MOTION_PARAM = 7'h09;
   localparam logic [6:0]  CMD_MOVE_TARGET  = 7'h0b;
   localparam logic [6:0]  CMD_SHORT_1      = 7'h0c;
   localparam logic [6:0]  CMD_SHORT_2      = 7'h0d;
   localparam logic [6:0]  CMD_SHORT_4      = 7'h0e;
   localparam logic [6:0]  CMD_DECEL_HALT   = 7'h0f;
   localparam logic [6:0]  CMD_OTP_PROG     = 7'h10;
   localparam logic [6:0]  CMD_ASSIGN_ID    = 7'h11;
   localparam int          SLOT_COUNT       = 9;
   localparam int          PAIRS_PER_FRAME  = 4;
   localparam logic [3:0]  SLOT_MAX         = 4'h8;
   localparam logic [10:0] SAFE_POS_NONE    = 11'h400;
   localparam logic [5:0]  ID_RESET_VAL     = 6'h00;
   localparam int          LOST_FRAMES      = 25000;
   localparam int          BAUD_RATE        = 19200;
   localparam int          CLK_HZ           = 100000000;
   // One LIN frame, about 52 bit times at this baud
   localparam int          FRAME_BITS       = 52;
   localparam int          FRAME_CYCLES     = (CLK_HZ / BAUD_RATE) * FRAME_BITS;

   typedef struct packed {
      logic [5:0] ident;
      logic [7:0] d1;
      logic [7:0] d2;
      logic [7:0] d3;
      logic [7:0] d4;
      logic [7:0] d5;
      logic [7:0] d6;
      logic [7:0] d7;
      logic [7:0] d8;
   } lindyn_frame_t;

   typedef struct packed {
      logic       read_cmd;
      logic       write_cmd;
      logic       assign_cmd;
   } lindyn_cmd_class_t;

   typedef enum logic [2:0] {
      ST_SHUTDOWN,
      ST_NORMAL,
      ST_SAFE_MOVE,
      ST_SLEEP
   } lindyn_state_t;
endpackage : lindyn_pkg
`default_nettype wire

// ==== tb/lindyn_lin_master.sv ====
// LIN master model: hands the controller checked frames on its frame port.
// Assumes mclk from the bench; frames change only at the falling edge.
`default_nettype none
module lindyn_lin_master (
   input  wire logic                  mclk,
   output var  lindyn_pkg::lindyn_frame_t frame_in,
   output var  logic                  frame_valid
);
   import lindyn_pkg::*;
   initial
   begin
      frame_valid = 1'b0;
      frame_in    = '0;
   end
   // Four pairs to a frame, so three frames fill all nine slots
   function automatic logic [39:0] pack_pairs(input logic [5:0] i1, i2, i3, i4,
                                              input logic [3:0] p1, p2, p3, p4);
      return {i1[3:0], p1, i2[1:0], p2, i1[5:4], p3, i2[5:2], p4[1:0], i3, i4, p4[3:2]};
   endfunction : pack_pairs
   task automatic send_cmd(input logic [7:0] cmd, input logic [7:0] addr, input logic [39:0] pay);
      @(negedge mclk);
      frame_in    = {ID_CMD_FRAME, APP_CMD_MARKER, cmd, addr, pay};
      frame_valid = 1'b1;
      @(negedge mclk);
      frame_valid = 1'b0;
      // Stale frame must not look valid
      frame_in    = ~frame_in;
   endtask : send_cmd
endmodule : lindyn_lin_master
`default_nettype wire

// ==== tb/lindyn_ctrl_monitor.sv ====
// Checker on the controller's ports, bound from the bench top.
// Assumes one clock domain and the asynchronous active-low reset.
`default_nettype none
module lindyn_ctrl_monitor #(
   parameter int LOST_FRAMES_P  = 4,
   parameter int FRAME_CYCLES_P = 8
) (
   input wire logic                      mclk,
   input wire logic                      arst_n,
   input wire logic                      frame_valid,
   input wire lindyn_pkg::lindyn_frame_t frame_in,
   input wire logic [10:0]               safe_target_pos,
   input wire logic [15:0]               move_target_pos,
   input wire logic                      safe_move_start,
   input wire logic                      motor_powered,
   input wire logic                      sleep_req,
   input wire logic                      bus_lost,
   input wire logic                      cmd_strobe,
   input wire lindyn_pkg::lindyn_cmd_class_t cmd_class
);
   import lindyn_pkg::*;
   localparam int LIM = LOST_FRAMES_P * FRAME_CYCLES_P;
   localparam int LO  = LIM - 1;
   localparam int HI  = LIM + 4;
   int idle_reg;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n) idle_reg <= 0;
      else if (frame_valid) idle_reg <= 0;
      else idle_reg <= idle_reg + 1;
   end
   assign_bcast_a: assert property (frame_valid && frame_in.ident == 6'h3c && frame_in.d1 == 8'h80
      && frame_in.d2 == 8'h91 && !frame_in.d3[7] |=> cmd_strobe && cmd_class.assign_cmd)
      else $error("broadcast assignment not taken");
   other_ident_a: assert property (frame_valid && frame_in.ident != 6'h3c |=> !cmd_strobe)
      else $error("strobe for non-command frame");
   lost_time_a: assert property ($rose(bus_lost) |-> idle_reg >= LO && idle_reg <= HI)
      else $error("bus lost at wrong idle count");
   lost_clear_a: assert property (frame_valid |=> !bus_lost)
      else $error("bus lost kept after frame");
   safe_target_a: assert property (safe_move_start |-> ##[0:1]
      move_target_pos == {{5{safe_target_pos[10]}}, safe_target_pos})
      else $error("target not loaded from safe position");
   no_move_a: assert property (safe_move_start |-> safe_target_pos != 11'h400)
      else $error("safe move with no safe position");
   sleep_hold_a: assert property (sleep_req |=> sleep_req && !motor_powered)
      else $error("sleep left or motor powered");
   shutdown_keep_a: assert property (!motor_powered && !sleep_req && !frame_valid
      |=> !motor_powered)
      else $error("shutdown left without a frame");
   strobe_pulse_a: assert property (cmd_strobe || safe_move_start |=> $fell(cmd_strobe)
      || $fell(safe_move_start) || (!cmd_strobe && !safe_move_start) || $past(frame_valid))
      else $error("pulse stood too long");
endmodule : lindyn_ctrl_monitor
`default_nettype wire

// ==== tb/lindyn_ctrl_test.sv ====
// Bench for the controller: master model, motion handshake, bus-loss cases.
// Assumes the design files compiled first; no other stimulus source.
`default_nettype none
module lindyn_ctrl_test;
   timeunit 1ns;
   timeprecision 1ps;
   import lindyn_pkg::*;
   localparam int LIM = 32;
   logic mclk = 1'b0, arst_n = 1'b0, pin2 = 1'b0, move_done = 1'b0, frame_valid;
   logic smstart, powered, sleep, lost, strobe, ind_ok;
   logic [10:0] safe_pos = 11'h400;
   logic [15:0] target;
   logic [6:0] code;
   logic [5:0] slots [SLOT_COUNT];
   lindyn_frame_t frame_in;
   lindyn_cmd_class_t cls;
   int errors = 0, checks = 0;
   always #5 mclk = ~mclk;
   lindyn_lin_master u_mst (.mclk(mclk), .frame_in(frame_in), .frame_valid(frame_valid));
   lindyn_ctrl #(.LOST_FRAMES_P(4), .FRAME_CYCLES_P(8)) u_dut (.mclk(mclk), .arst_n(arst_n),
      .frame_valid(frame_valid), .frame_in(frame_in), .node_addr(7'h05),
      .hardwired_addr_pin_two_float(pin2), .safe_target_pos(safe_pos),
      .current_pos_reg(16'h0000), .move_done(move_done), .assigned_frame_ident(slots),
      .move_target_pos(target), .safe_move_start(smstart), .motor_powered(powered),
      .sleep_req(sleep), .bus_lost(lost), .cmd_strobe(strobe), .cmd_code(code),
      .cmd_class(cls), .indirect_read_ok(ind_ok));
   // Wide enough for four 6-bit slots side by side
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD %0t %s", $time, what);
      end
   endtask : chk
   task automatic do_reset();
      arst_n = 1'b0;
      repeat (10) @(negedge mclk);
      arst_n = 1'b1;
      repeat (3) @(negedge mclk);
   endtask : do_reset
   task automatic wake();
      u_mst.send_cmd(8'h81, 8'h85, 40'h0);
      chk(powered, 1'b1, "full read did not power");
   endtask : wake
   task automatic t_shutdown();
      repeat (LIM + 20) @(negedge mclk);
      chk(lost, 1'b1, "bus lost missing");
      chk({powered, sleep}, 2'b00, "shutdown left");
   endtask : t_shutdown
   task automatic t_assign();
      wake();
      // Broadcast reaches every node whatever its address
      u_mst.send_cmd(8'h91, 8'h7f,
                     u_mst.pack_pairs(6'h25, 6'h15, 6'h2a, 6'h07, 4'h2, 4'h3, 4'h4, 4'h8));
      chk({strobe, cls}, 4'h9, "assignment not decoded");
      chk({slots[2], slots[3], slots[4], slots[8]}, {6'h25, 6'h15, 6'h2a, 6'h07}, "slots");
      u_mst.send_cmd(8'h91, 8'h86,
                     u_mst.pack_pairs(6'h01, 6'h01, 6'h01, 6'h01, 4'h2, 4'h2, 4'h2, 4'h2));
      chk(slots[2], 6'h25, "foreign address stored");
      u_mst.send_cmd(8'h91, 8'h85,
                     u_mst.pack_pairs(6'h11, 6'h3c, 6'h3f, 6'h0a, 4'h9, 4'h0, 4'h1, 4'h8));
      chk({slots[0], slots[1]}, 12'h000, "reserved id or bad pointer stored");
      chk(slots[8], 6'h0a, "matching address not stored");
   endtask : t_assign
   task automatic t_codes();
      logic [2:0] exp;
      for (int c = 0; c <= 17; c++)
      begin
         // 0x0a is no command: strobed with no class bit
         exp = (c <= 3) ? 3'b100 : (c == 17) ? 3'b001 : (c == 10) ? 3'b000 : 3'b010;
         u_mst.send_cmd({1'b1, 7'(c)}, 8'h85, 40'h0);
         chk({strobe, code, cls}, {1'b1, 7'(c), exp}, "command class");
      end
      u_mst.send_cmd(8'h80, 8'h85, 40'h0);
      chk(ind_ok, 1'b1, "preparing frame missed");
      u_mst.send_cmd(8'h85, 8'h85, 40'h0);
      chk(ind_ok, 1'b0, "indirect read kept");
      u_mst.send_cmd(8'h80, 8'h86, 40'h0);
      chk(ind_ok, 1'b0, "foreign preparing frame");
   endtask : t_codes
   task automatic t_safe(input logic [10:0] pos, input logic float, input logic [15:0] exp);
      int n;
      logic seen;
      do_reset();
      safe_pos = pos;
      seen = 1'b0;
      wake();
      pin2 = float;
      if (!float)
      begin
         repeat (LIM - 6) @(negedge mclk);
         chk(lost, 1'b0, "bus lost too early");
      end
      for (n = 0; n < 100 && sleep !== 1'b1 && smstart !== 1'b1; n++) @(negedge mclk);
      seen = smstart;
      // Float must act long before the silent-frame count could
      if (float)
         chk(n < 8, 1'b1, "float not taken as bus loss");
      if (pos == SAFE_POS_NONE)
         chk({seen, sleep}, 2'b01, "direct sleep");
      else
      begin
         chk(seen, 1'b1, "safe move not started");
         @(negedge mclk);
         chk(target, exp, "safe target");
         chk({powered, sleep}, 2'b10, "slept before move done");
         move_done = 1'b1;
         repeat (3) @(negedge mclk);
         chk({powered, sleep}, 2'b01, "no sleep after move");
      end
      move_done = 1'b0;
      pin2 = 1'b0;
   endtask : t_safe
   task automatic tally_and_finish();
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : tally_and_finish
   initial
   begin
      #50000;
      errors++;
      tally_and_finish();
   end
   initial
   begin
      do_reset();
      t_shutdown();
      t_assign();
      t_codes();
      t_safe(11'h123, 1'b0, 16'h0123);
      t_safe(11'h400, 1'b0, 16'h0000);
      t_safe(11'h5a5, 1'b1, 16'hfda5);
      tally_and_finish();
   end
endmodule : lindyn_ctrl_test
bind lindyn_ctrl lindyn_ctrl_monitor #(.LOST_FRAMES_P(LOST_FRAMES_P),
   .FRAME_CYCLES_P(FRAME_CYCLES_P)) u_mon (.mclk(mclk), .arst_n(arst_n),
   .frame_valid(frame_valid), .frame_in(frame_in), .safe_target_pos(safe_target_pos),
   .move_target_pos(move_target_pos), .safe_move_start(safe_move_start),
   .motor_powered(motor_powered), .sleep_req(sleep_req), .bus_lost(bus_lost),
   .cmd_strobe(cmd_strobe), .cmd_class(cmd_class));
`default_nettype wire
